// file: hdl/csr_route_map.vh
`ifndef CSR_ROUTE_MAP_VH
`define CSR_ROUTE_MAP_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CSR_OFS_DRIVER     12'h340
`define CSR_OFS_SOURCE     12'h344
`define CSR_OFS_LINE_OE_N  12'h348
`define CSR_OFS_LINE_OUT   12'h34c
`define CSR_OFS_STATUS     12'h350
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSR_FLD_CLK1_LSB   0
`define CSR_FLD_CLK2_LSB   2
`define CSR_FLD_FRAME_LSB  4
// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define CSR_CODE_REAR      2'b10
`define CSR_CODE_FRONT     2'b11
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSR_RST_DRIVER     6'h00
`define CSR_RST_SOURCE     6'h00
`define CSR_RST_LINE_OE_N  8'h00   // No line driven until software asks
`define CSR_RST_LINE_OUT   8'h00
`endif

// file: hdl/csr_sync2.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Two-stage synchroniser for a bundle of pins
// ----------------------------------------------------------------
module csr_sync2 #(
    parameter W = 8
) (
    input  wire         core_clk_i,
    input  wire         srst_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage is read only by the second stage
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// file: hdl/csr_route.v
// Contract
// - Clock-1 driver field 1:0: 0x off, 10 rear pin, 11 front line 1.
// - Clock-2 driver field 3:2: 10 rear pin, 11 front line 3.
// - Frame driver field 5:4: 0x off, 10 rear pin, 11 front line 5.
// - Generator reaches front line only if selected and line enable_n cleared.
// - Set line output enable drives line output register, overriding generators.
// - Selected sources feed the internal clocks and frame pulse to sequencers.
// - Frame source field 5:4: 0x generator, 10 rear input, 11 line 5.
// - Clock-2 source field 3:2: 10 rear input, 11 line 3.
// - Clock-1 source field 1:0: 0x generator, 10 rear input, 11 line 1.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "csr_route_map.vh"
module csr_route (
    input  wire        core_clk_i,
    input  wire        srst_i,
    // AHB-Lite slave
    input  wire        hsel_i,
    input  wire [11:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    // On-board generator outputs (same clock domain)
    input  wire        gen_clk1_i,
    input  wire        gen_clk2_i,
    input  wire        gen_frame_i,
    // Rear connector pins
    input  wire        rear_clk1_i,
    input  wire        rear_clk2_i,
    input  wire        rear_frame_i,
    output wire        rear_clk1_o,
    output wire        rear_clk1_oe_o,
    output wire        rear_clk2_o,
    output wire        rear_clk2_oe_o,
    output wire        rear_frame_o,
    output wire        rear_frame_oe_o,
    // Front digital lines, index 0 is line 1
    input  wire [7:0]  line_i,
    output wire [7:0]  line_o,
    output wire [7:0]  line_oe_o,
    // Signals to the conversion sequencers
    output wire        first_conversion_clock_o,
    output wire        second_conversion_clock_o,
    output wire        frame_pulse_o
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Source pick for one signal by its 2-bit select code
    function pick_src;
        input [1:0] code;
        input       gen;
        input       rear;
        input       front;
        begin
            if (code == `CSR_CODE_REAR) begin
                pick_src = rear;
            end else if (code == `CSR_CODE_FRONT) begin
                pick_src = front;
            end else begin
                pick_src = gen;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [5:0]  drv_q;
    reg  [5:0]  src_q;
    reg  [7:0]  line_oe_n_q;
    reg  [7:0]  line_out_q;
    reg         wr_pend_q;
    reg  [11:0] wr_addr_q;
    reg  [31:0] rdata_q;
    reg  [2:0]  rear_out_q;
    reg  [2:0]  rear_oe_q;
    reg  [7:0]  line_o_q;
    reg  [7:0]  line_oe_q;
    reg  [2:0]  conv_q;

    wire [7:0]  line_sync;
    wire [2:0]  rear_sync;
    wire [1:0]  first_clock_driver_select;
    wire [1:0]  second_clock_driver_select;
    wire [1:0]  frame_pulse_driver_select;
    wire [1:0]  first_clock_source_select;
    wire [1:0]  second_clock_source_select;
    wire [1:0]  frame_pulse_source_select;
    wire [7:0]  line_output_enable_n;
    wire        addr_ok;
    wire        rd_req;
    wire        wr_req;
    reg  [31:0] rd_mux;
    reg  [7:0]  line_nxt;
    reg  [7:0]  line_oe_nxt;

    assign first_clock_driver_select  = drv_q[`CSR_FLD_CLK1_LSB +: 2];
    assign second_clock_driver_select = drv_q[`CSR_FLD_CLK2_LSB +: 2];
    assign frame_pulse_driver_select  = drv_q[`CSR_FLD_FRAME_LSB +: 2];
    assign first_clock_source_select  = src_q[`CSR_FLD_CLK1_LSB +: 2];
    assign second_clock_source_select = src_q[`CSR_FLD_CLK2_LSB +: 2];
    assign frame_pulse_source_select  = src_q[`CSR_FLD_FRAME_LSB +: 2];
    assign line_output_enable_n       = line_oe_n_q;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    csr_sync2 #(.W(8)) u_line_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    (line_i),
        .sync_o     (line_sync)
    );

    csr_sync2 #(.W(3)) u_rear_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    ({rear_frame_i, rear_clk2_i, rear_clk1_i}),
        .sync_o     (rear_sync)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ------------------------------------------------------------
    assign addr_ok = (haddr_i == `CSR_OFS_DRIVER) || (haddr_i == `CSR_OFS_SOURCE) ||
                     (haddr_i == `CSR_OFS_LINE_OE_N) || (haddr_i == `CSR_OFS_LINE_OUT) ||
                     (haddr_i == `CSR_OFS_STATUS);
    assign rd_req  = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    assign wr_req  = hsel_i && hready_i && htrans_i[1] && hwrite_i;

    // Read decode; unmapped addresses read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr_i)
            `CSR_OFS_DRIVER:    rd_mux = {26'h0, drv_q};
            `CSR_OFS_SOURCE:    rd_mux = {26'h0, src_q};
            `CSR_OFS_LINE_OE_N: rd_mux = {24'h0, line_oe_n_q};
            `CSR_OFS_LINE_OUT:  rd_mux = {24'h0, line_out_q};
            `CSR_OFS_STATUS:    rd_mux = {13'h0, conv_q, 8'h00, line_sync};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Write data lands one cycle after the address phase
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 12'h000;
            rdata_q     <= 32'h0000_0000;
            drv_q       <= `CSR_RST_DRIVER;
            src_q       <= `CSR_RST_SOURCE;
            line_oe_n_q <= `CSR_RST_LINE_OE_N;
            line_out_q  <= `CSR_RST_LINE_OUT;
        end else begin
            wr_pend_q <= wr_req && addr_ok;
            wr_addr_q <= haddr_i;
            if (rd_req) begin
                rdata_q <= rd_mux;
            end
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `CSR_OFS_DRIVER:    drv_q       <= hwdata_i[5:0];
                    `CSR_OFS_SOURCE:    src_q       <= hwdata_i[5:0];
                    `CSR_OFS_LINE_OE_N: line_oe_n_q <= hwdata_i[7:0];
                    `CSR_OFS_LINE_OUT:  line_out_q  <= hwdata_i[7:0];
                    default:            drv_q       <= drv_q;
                endcase
            end
        end
    end

    assign hrdata_o    = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // ------------------------------------------------------------
    // Front line drive
    // ------------------------------------------------------------
    // Set enable bit: register value wins; cleared bit lets a selected generator out
    always @* begin
        line_nxt    = line_out_q;
        line_oe_nxt = line_output_enable_n;
        if (!line_output_enable_n[0] && first_clock_driver_select == `CSR_CODE_FRONT) begin
            line_nxt[0]    = gen_clk1_i;
            line_oe_nxt[0] = 1'b1;
        end
        if (!line_output_enable_n[2] && second_clock_driver_select == `CSR_CODE_FRONT) begin
            line_nxt[2]    = gen_clk2_i;
            line_oe_nxt[2] = 1'b1;
        end
        if (!line_output_enable_n[4] && frame_pulse_driver_select == `CSR_CODE_FRONT) begin
            line_nxt[4]    = gen_frame_i;
            line_oe_nxt[4] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Output flops: one cycle of latency, glitch-free pins
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            rear_out_q <= 3'b000;
            rear_oe_q  <= 3'b000;
            line_o_q   <= 8'h00;
            line_oe_q  <= 8'h00;
            conv_q     <= 3'b000;
        end else begin
            rear_out_q <= {gen_frame_i, gen_clk2_i, gen_clk1_i};
            rear_oe_q  <= {frame_pulse_driver_select == `CSR_CODE_REAR,
                           second_clock_driver_select == `CSR_CODE_REAR,
                           first_clock_driver_select == `CSR_CODE_REAR};
            line_o_q   <= line_nxt;
            line_oe_q  <= line_oe_nxt;
            // Front picks read the received line level
            conv_q[0]  <= pick_src(first_clock_source_select, gen_clk1_i,
                                   rear_sync[0], line_sync[0]);
            conv_q[1]  <= pick_src(second_clock_source_select, gen_clk2_i,
                                   rear_sync[1], line_sync[2]);
            conv_q[2]  <= pick_src(frame_pulse_source_select, gen_frame_i,
                                   rear_sync[2], line_sync[4]);
        end
    end

    assign rear_clk1_o     = rear_out_q[0];
    assign rear_clk2_o     = rear_out_q[1];
    assign rear_frame_o    = rear_out_q[2];
    assign rear_clk1_oe_o  = rear_oe_q[0];
    assign rear_clk2_oe_o  = rear_oe_q[1];
    assign rear_frame_oe_o = rear_oe_q[2];
    assign line_o          = line_o_q;
    assign line_oe_o       = line_oe_q;
    // Sequencers see the selected sources
    assign first_conversion_clock_o  = conv_q[0];
    assign second_conversion_clock_o = conv_q[1];
    assign frame_pulse_o             = conv_q[2];
endmodule

// file: test/csr_route_far.sv
`timescale 1ns/100ps
module csr_route_far (
    input  wire [2:0] rear_want_i,
    input  wire [7:0] line_want_i,
    input  wire [7:0] dut_line_i,
    input  wire [7:0] dut_oe_i,
    output wire [2:0] rear_o,
    output wire [7:0] line_o
);
    // Far card keeps its drivers off wherever this card drives, so no contention
    assign line_o = (dut_oe_i & dut_line_i) | (~dut_oe_i & line_want_i);
    // Rear pins come from another board or an external generator
    assign rear_o = rear_want_i;
endmodule

// file: test/csr_route_asserts.sv
`timescale 1ns/100ps
`include "csr_route_map.vh"
module csr_route_asserts (
    input wire        core_clk_i,
    input wire        srst_i,
    input wire        hsel_i,
    input wire [11:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire        gen_clk1_i,
    input wire        rear_clk2_i,
    input wire [7:0]  line_i,
    input wire        rear_clk1_o,
    input wire        rear_clk1_oe_o,
    input wire        rear_clk2_oe_o,
    input wire        rear_frame_oe_o,
    input wire [7:0]  line_o,
    input wire [7:0]  line_oe_o,
    input wire        first_conversion_clock_o,
    input wire        second_conversion_clock_o,
    input wire        frame_pulse_o
);
    reg        wp_q;
    reg [11:0] wa_q;
    reg [27:0] sh_q;
    wire [5:0] drv = sh_q[5:0];
    wire [5:0] src = sh_q[11:6];
    wire [7:0] enn = sh_q[19:12];
    wire [7:0] out = sh_q[27:20];
    // Shadow of the settings, snooped from bus writes
    always @(posedge core_clk_i) begin
        wp_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && !srst_i;
        wa_q <= haddr_i;
        if (srst_i)
            sh_q <= 28'h0000000;
        else if (wp_q && wa_q == `CSR_OFS_DRIVER)
            sh_q[5:0] <= hwdata_i[5:0];
        else if (wp_q && wa_q == `CSR_OFS_SOURCE)
            sh_q[11:6] <= hwdata_i[5:0];
        else if (wp_q && wa_q == `CSR_OFS_LINE_OE_N)
            sh_q[19:12] <= hwdata_i[7:0];
        else if (wp_q && wa_q == `CSR_OFS_LINE_OUT)
            sh_q[27:20] <= hwdata_i[7:0];
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // Pin path is sync plus output stage, three edges
    sequence s_src_rear;
        $past(src[3:2]) == `CSR_CODE_REAR;
    endsequence
    a_rear_clk1: assert property (rear_clk1_oe_o == ($past(drv[1:0]) == 2'b10))
        else $error("clock 1 rear driver wrong");
    a_rear_clk2: assert property (rear_clk2_oe_o == ($past(drv[3:2]) == 2'b10))
        else $error("clock 2 rear driver wrong");
    a_rear_frame: assert property (rear_frame_oe_o == ($past(drv[5:4]) == 2'b10))
        else $error("frame rear driver wrong");
    a_rear_copy: assert property (rear_clk1_oe_o |-> rear_clk1_o == $past(gen_clk1_i))
        else $error("rear pin not generator copy");
    a_line_gen: assert property ((!$past(enn[0]) && $past(drv[1:0]) == 2'b11)
        |-> line_oe_o[0] && line_o[0] == $past(gen_clk1_i))
        else $error("line 1 generator drive wrong");
    a_line_only: assert property (line_oe_o[1] == $past(enn[1]))
        else $error("line 2 driven without cause");
    a_line_reg: assert property ($past(enn[2]) |-> line_oe_o[2] && line_o[2] == $past(out[2]))
        else $error("line 3 register drive lost");
    a_conv_gen: assert property ((!$past(srst_i) && !$past(src[1]))
        |-> first_conversion_clock_o == $past(gen_clk1_i))
        else $error("clock 1 generator source wrong");
    a_conv_rear: assert property (s_src_rear |-> second_conversion_clock_o == $past(rear_clk2_i, 3))
        else $error("clock 2 rear source wrong");
    a_frame_line: assert property (($past(src[5:4]) == 2'b11) |-> frame_pulse_o == $past(line_i[4], 3))
        else $error("frame line source wrong");
endmodule
bind csr_route csr_route_asserts u_chk (.*);

// file: test/csr_route_test.sv
`timescale 1ns/100ps
`include "csr_route_map.vh"
module csr_route_test;
    reg         core_clk_i, srst_i, hsel_i, hwrite_i;
    reg  [11:0] haddr_i;
    reg  [1:0]  htrans_i;
    reg  [2:0]  hsize_i;
    reg  [31:0] hwdata_i, rd;
    reg         gen_clk1_i, gen_clk2_i, gen_frame_i;
    reg  [2:0]  rw;
    reg  [7:0]  lw;
    reg  [63:0] row [0:5];
    integer     errors, cmp_count, i;
    wire        hready_i, hreadyout_o, hresp_o, rear_clk1_i, rear_clk2_i, rear_frame_i;
    wire        rear_clk1_o, rear_clk1_oe_o, rear_clk2_o, rear_clk2_oe_o, rear_frame_o;
    wire        rear_frame_oe_o, first_conversion_clock_o, second_conversion_clock_o;
    wire        frame_pulse_o;
    wire [31:0] hrdata_o;
    wire [7:0]  line_i, line_o, line_oe_o;
    assign hready_i = hreadyout_o;
    csr_route DUT (.*);
    csr_route_far far (.rear_want_i(rw), .line_want_i(lw), .dut_line_i(line_o),
        .dut_oe_i(line_oe_o), .rear_o({rear_frame_i, rear_clk2_i, rear_clk1_i}), .line_o(line_i));
    // Core clock, 100 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task print_verdict;
        begin
            $display("errors %0d compares %0d", errors, cmp_count);
            if (errors == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [95:0] nm, input [31:0] e, input [31:0] s);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("MISMATCH %0s exp %h seen %h", nm, e, s);
            end
        end
    endtask
    // Bounded ready wait, so a stuck slave still ends the run
    task wrdy;
        integer n;
        begin
            n = 0;
            @(posedge core_clk_i);
            while (hreadyout_o !== 1'b1) begin
                n = n + 1;
                if (n > 20) begin
                    errors = errors + 1;
                    print_verdict;
                end
                @(posedge core_clk_i);
            end
        end
    endtask
    // Single word transfer: address phase, then data phase
    task bus(input [11:0] a, input w, input [31:0] d);
        begin
            hsel_i <= 1'b1;
            haddr_i <= a;
            hwrite_i <= w;
            htrans_i <= 2'b10;
            wrdy;
            htrans_i <= 2'b00;
            hwdata_i <= d;
            wrdy;
            rd = hrdata_o;
        end
    endtask
    task rchk(input [11:0] a, input [31:0] e);
        begin
            bus(a, 1'b0, 32'h0);
            chk("readback", e, rd);
            chk("hresp", 32'h0, hresp_o);
        end
    endtask
    // Rows: drv, src, enable_n, out, gen, rear, far lines | line_o, line_oe, rear oe, conv
    initial begin
        row[0] = {6'h00, 6'h00, 8'h00, 8'h00, 3'h5, 3'h2, 8'h00, 8'h00, 8'h00, 3'h0, 3'h5};
        row[1] = {6'h2a, 6'h2a, 8'h00, 8'h00, 3'h3, 3'h6, 8'h00, 8'h00, 8'h00, 3'h7, 3'h6};
        row[2] = {6'h3f, 6'h3f, 8'h00, 8'h00, 3'h5, 3'h0, 8'h00, 8'h11, 8'h15, 3'h0, 3'h5};
        row[3] = {6'h3f, 6'h00, 8'h1e, 8'h0a, 3'h7, 3'h0, 8'hff, 8'h0b, 8'h1f, 3'h0, 3'h7};
        row[4] = {6'h15, 6'h15, 8'h00, 8'h00, 3'h6, 3'h1, 8'h00, 8'h00, 8'h00, 3'h0, 3'h6};
        row[5] = {6'h2c, 6'h38, 8'h00, 8'h00, 3'h3, 3'h5, 8'h10, 8'h04, 8'h04, 3'h4, 3'h5};
    end
    // Main sequence; reset values, the row loop, then the awkward cases
    initial begin
        errors = 0;
        cmp_count = 0;
        srst_i = 1'b1;
        hsize_i = 3'h2;
        {hsel_i, haddr_i, htrans_i, hwrite_i, hwdata_i, gen_clk1_i, gen_clk2_i, gen_frame_i, rw, lw} = 0;
        repeat (12) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        chk("line_oe", 32'h0, line_oe_o);
        rchk(`CSR_OFS_DRIVER, 32'h0);
        rchk(`CSR_OFS_SOURCE, 32'h0);
        rchk(`CSR_OFS_LINE_OE_N, 32'h00);
        rchk(`CSR_OFS_LINE_OUT, 32'h0);
        for (i = 0; i < 6; i = i + 1) begin
            bus(`CSR_OFS_DRIVER, 1'b1, row[i][63:58]);
            bus(`CSR_OFS_SOURCE, 1'b1, row[i][57:52]);
            bus(`CSR_OFS_LINE_OE_N, 1'b1, row[i][51:44]);
            bus(`CSR_OFS_LINE_OUT, 1'b1, row[i][43:36]);
            {gen_frame_i, gen_clk2_i, gen_clk1_i} <= row[i][35:33];
            rw <= row[i][32:30];
            lw <= row[i][29:22];
            rchk(`CSR_OFS_SOURCE, row[i][57:52]);
            repeat (6) @(posedge core_clk_i);
            chk("line_o", row[i][21:14], line_o & line_oe_o);
            chk("line_oe", row[i][13:6], line_oe_o);
            chk("rear_oe", row[i][5:3], {rear_frame_oe_o, rear_clk2_oe_o, rear_clk1_oe_o});
            chk("rear_o", row[i][35:33], {rear_frame_o, rear_clk2_o, rear_clk1_o});
            chk("conv", row[i][2:0],
                {frame_pulse_o, second_conversion_clock_o, first_conversion_clock_o});
        end
        bus(`CSR_OFS_DRIVER, 1'b1, 32'hffffffff);
        rchk(`CSR_OFS_DRIVER, 32'h3f);
        bus(12'h3fc, 1'b1, 32'h5a);
        rchk(12'h3fc, 32'h0);
        srst_i <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        rchk(`CSR_OFS_DRIVER, 32'h0);
        chk("rear_oe", 32'h0, {rear_frame_oe_o, rear_clk2_oe_o, rear_clk1_oe_o});
        print_verdict;
    end
endmodule
